/* File: logic/btwdc_pkg.sv */
package btwdc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] DIAG_CTRL_OFFS = 8'h40;
  localparam logic [7:0] BRIDGE_UP_OFFS = 8'h3c;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h50;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h54;
  localparam logic [7:0] XACT_STAT_OFFS = 8'h58;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PRI_TMO_SEL_BIT = 24;
  localparam int SEC_TMO_SEL_BIT = 25;
  localparam int TMO_STAT_BIT = 26;
  localparam int DISCARD_BIT = 27;
  localparam int WR_DISC_BIT = 1;
  localparam int IRQ_PRI_TMO_BIT = 0;
  localparam int IRQ_SEC_TMO_BIT = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic RST_VAL = 1'b0;
  localparam int LONG_TMO_LOG2 = 15;
  localparam int SHORT_TMO_LOG2 = 10;
  localparam int LINE_BYTES = 64;
  localparam int PAGE_BYTES = 4096;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic queued;
    logic repeated;
    logic retire;
  } btwdc_xact_t;

  typedef enum logic [1:0] {
    BUS_OKAY = 2'b00,
    BUS_SLVERR = 2'b10
  } btwdc_resp_t;

endpackage : btwdc_pkg

/* File: logic/btwdc_ctrl.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - Secondary head transaction starts its timer; expiry discards it.
// - Select bit zero gives 2^15 clocks, one gives 2^10; both reset zero.
// - Primary head transactions use the primary timer the same way.
// - Any timer expiry sets sticky timeout status; writing one clears it.
// - Any discard timer expiry sets discard bit and pulses primary error.
// - Disconnect bit zero cuts writes at 4KB boundary, one at cache line.
// - Reserved register bits read zero, reset zero, ignore writes.
module btwdc_ctrl #(
  parameter int LONG_LOG2 = btwdc_pkg::LONG_TMO_LOG2,
  parameter int SHORT_LOG2 = btwdc_pkg::SHORT_TMO_LOG2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Delayed transaction queues
  input wire btwdc_pkg::btwdc_xact_t priXact,
  input wire btwdc_pkg::btwdc_xact_t secXact,
  output logic priDiscard,
  output logic secDiscard,
  // Target write disconnect
  input wire logic [31:0] wrAddr,
  input wire logic wrActive,
  output logic wrDisconnect,
  // Error and interrupt
  output logic primary_system_error_n,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  logic priSel_q;
  logic secSel_q;
  logic tmoStat_q;
  logic discard_q;
  logic wrDiscSel_q;
  logic [btwdc_pkg::IRQ_W-1:0] irqStat_q;
  logic [btwdc_pkg::IRQ_W-1:0] irqMask_q;
  logic [1:0] expire;

  // ----------------------------------------------------------------------
  // Timeout counters
  // ----------------------------------------------------------------------
  function automatic logic [LONG_LOG2:0] tmoLen(input logic sel);
    tmoLen = sel ? (LONG_LOG2+1)'(1) << SHORT_LOG2
                 : (LONG_LOG2+1)'(1) << LONG_LOG2;
  endfunction : tmoLen

  btwdc_pkg::btwdc_xact_t xact [2];
  logic [1:0] sel;
  logic [1:0] discard_d;
  assign xact[0] = priXact;
  assign xact[1] = secXact;
  assign sel = {secSel_q, priSel_q};

  for (genvar i = 0; i < 2; i++) begin : g_tmr
    logic [LONG_LOG2:0] cnt_q;
    logic run_q;
    logic disc_q;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cnt_q <= '0;
        run_q <= 1'b0;
        disc_q <= 1'b0;
      end else begin
        disc_q <= 1'b0;
        if (!xact[i].queued || xact[i].retire) begin
          run_q <= 1'b0;
          cnt_q <= '0;
        end else if (xact[i].repeated) begin
          run_q <= 1'b0;
        end else if (!run_q && cnt_q == '0) begin
          run_q <= 1'b1;
          cnt_q <= (LONG_LOG2+1)'(1);
        end else if (run_q) begin
          if (cnt_q >= tmoLen(sel[i])) begin
            run_q <= 1'b0;
            disc_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + (LONG_LOG2+1)'(1);
          end
        end
      end
    end
    assign expire[i] = disc_q;
  end

  // ----------------------------------------------------------------------
  // Discard outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      priDiscard <= 1'b0;
      secDiscard <= 1'b0;
    end else begin
      priDiscard <= expire[0];
      secDiscard <= expire[1];
    end
  end

  // ----------------------------------------------------------------------
  // Write disconnect
  // ----------------------------------------------------------------------
  logic atPage;
  logic atLine;
  assign atPage = &wrAddr[$clog2(btwdc_pkg::PAGE_BYTES)-1:2];
  assign atLine = &wrAddr[$clog2(btwdc_pkg::LINE_BYTES)-1:2];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrDisconnect <= 1'b0;
    end else begin
      wrDisconnect <= wrActive && (wrDiscSel_q ? atLine : atPage);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  logic [7:0] awAddr_q;
  logic awHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHave_q;
  logic doWrite;
  logic wrOne;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awAddr_q <= '0;
      awHave_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      wHave_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= btwdc_pkg::BUS_OKAY;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready;
      s_axi_wready <= !wHave_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOne ? btwdc_pkg::BUS_OKAY : btwdc_pkg::BUS_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wrOne = awAddr_q == btwdc_pkg::DIAG_CTRL_OFFS ||
                 awAddr_q == btwdc_pkg::BRIDGE_UP_OFFS ||
                 awAddr_q == btwdc_pkg::IRQ_MASK_OFFS ||
                 awAddr_q == btwdc_pkg::IRQ_STAT_OFFS ||
                 awAddr_q == btwdc_pkg::XACT_STAT_OFFS;

  // ----------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] a, input logic [3:0] s,
                                  input logic [7:0] offs, input int lane);
    regHit = a == offs && s[lane];
  endfunction : regHit

  logic upWr;
  logic diagWr;
  logic maskWr;
  assign upWr = doWrite && regHit(awAddr_q, wStrb_q,
                btwdc_pkg::BRIDGE_UP_OFFS, btwdc_pkg::PRI_TMO_SEL_BIT / 8);
  assign diagWr = doWrite && regHit(awAddr_q, wStrb_q,
                  btwdc_pkg::DIAG_CTRL_OFFS, btwdc_pkg::WR_DISC_BIT / 8);
  assign maskWr = doWrite && regHit(awAddr_q, wStrb_q,
                  btwdc_pkg::IRQ_MASK_OFFS, btwdc_pkg::IRQ_PRI_TMO_BIT / 8);

  // ----------------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      priSel_q <= btwdc_pkg::RST_VAL;
      secSel_q <= btwdc_pkg::RST_VAL;
    end else if (upWr) begin
      priSel_q <= wData_q[btwdc_pkg::PRI_TMO_SEL_BIT];
      secSel_q <= wData_q[btwdc_pkg::SEC_TMO_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrDiscSel_q <= btwdc_pkg::RST_VAL;
    end else if (diagWr) begin
      wrDiscSel_q <= wData_q[btwdc_pkg::WR_DISC_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tmoStat_q <= btwdc_pkg::RST_VAL;
    end else if (|expire) begin
      tmoStat_q <= 1'b1;
    end else if (upWr && wData_q[btwdc_pkg::TMO_STAT_BIT]) begin
      tmoStat_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      discard_q <= btwdc_pkg::RST_VAL;
    end else if (|expire) begin
      discard_q <= 1'b1;
    end else if (upWr) begin
      discard_q <= wData_q[btwdc_pkg::DISCARD_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // System error output
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_system_error_n <= 1'b1;
    end else begin
      primary_system_error_n <= !(|expire);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic statRd;
  assign statRd = s_axi_arvalid && s_axi_arready &&
                  s_axi_araddr == btwdc_pkg::IRQ_STAT_OFFS;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (statRd ? '0 : irqStat_q) | expire;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqMask_q <= '0;
    end else if (maskWr) begin
      irqMask_q <= wData_q[btwdc_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((statRd ? '0 : irqStat_q) | expire) & irqMask_q);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  logic [31:0] rdMux;
  logic rdOk;

  always_comb begin
    rdMux = '0;
    rdOk = 1'b1;
    unique case (s_axi_araddr)
      btwdc_pkg::DIAG_CTRL_OFFS: begin
        rdMux[btwdc_pkg::WR_DISC_BIT] = wrDiscSel_q;
      end
      btwdc_pkg::BRIDGE_UP_OFFS: begin
        rdMux[btwdc_pkg::PRI_TMO_SEL_BIT] = priSel_q;
        rdMux[btwdc_pkg::SEC_TMO_SEL_BIT] = secSel_q;
        rdMux[btwdc_pkg::TMO_STAT_BIT] = tmoStat_q;
        rdMux[btwdc_pkg::DISCARD_BIT] = discard_q;
      end
      btwdc_pkg::IRQ_STAT_OFFS: begin
        rdMux[btwdc_pkg::IRQ_W-1:0] = irqStat_q | expire;
      end
      btwdc_pkg::IRQ_MASK_OFFS: begin
        rdMux[btwdc_pkg::IRQ_W-1:0] = irqMask_q;
      end
      btwdc_pkg::XACT_STAT_OFFS: begin
        rdMux[3:0] = {g_tmr[1].run_q, g_tmr[0].run_q, secXact.queued,
                      priXact.queued};
      end
      default: begin
        rdOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= btwdc_pkg::BUS_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? btwdc_pkg::BUS_OKAY : btwdc_pkg::BUS_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : btwdc_ctrl

/* File: tb/btwdc_props.sv */
`timescale 1ns/1ps
module btwdc_props #(
  parameter int LONG_LOG2 = 15,
  parameter int SHORT_LOG2 = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire btwdc_pkg::btwdc_xact_t priXact,
  input wire btwdc_pkg::btwdc_xact_t secXact,
  input wire logic priDiscard,
  input wire logic secDiscard,
  input wire logic [31:0] wrAddr,
  input wire logic wrActive,
  input wire logic wrDisconnect,
  input wire logic primary_system_error_n
);
  localparam int MINW = 1 << SHORT_LOG2;
  localparam int MAXW = (1 << LONG_LOG2) + 8;
  logic [31:0] pAge_q, sAge_q;
  logic pRep_q, sRep_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Age and repeat history of each queue head
  always_ff @(posedge core_clk) begin
    pAge_q <= (rst_n && priXact.queued) ? pAge_q + 32'h1 : 32'h0;
    sAge_q <= (rst_n && secXact.queued) ? sAge_q + 32'h1 : 32'h0;
    pRep_q <= rst_n && priXact.queued && (pRep_q || priXact.repeated);
    sRep_q <= rst_n && secXact.queued && (sRep_q || secXact.repeated);
  end
  early_disc_a: assert property (
    (priDiscard |-> pAge_q >= MINW) and (secDiscard |-> sAge_q >= MINW))
    else $error("discard too early");
  late_disc_a: assert property (
    (priXact.queued && !pRep_q |-> pAge_q <= MAXW) and
    (secXact.queued && !sRep_q |-> sAge_q <= MAXW)) else $error("no discard");
  repeat_keeps_a: assert property (
    (priDiscard |-> !pRep_q) and (secDiscard |-> !sRep_q))
    else $error("repeated request discarded");
  disc_pulse_a: assert property (
    (priDiscard |=> !priDiscard) and (secDiscard |=> !secDiscard))
    else $error("discard longer than a cycle");
  err_follows_a: assert property (
    priDiscard || secDiscard |-> ##[0:1] !primary_system_error_n)
    else $error("error line not asserted");
  err_cause_a: assert property (
    !primary_system_error_n |-> priDiscard || secDiscard ||
    $past(priDiscard || secDiscard)) else $error("error without discard");
  page_cut_a: assert property (
    wrActive && wrAddr[11:2] == 10'h3ff |=> wrDisconnect)
    else $error("no disconnect at page end");
  cut_cause_a: assert property (
    wrDisconnect |-> $past(wrActive) && ($past(wrAddr) & 32'h3c) == 32'h3c)
    else $error("disconnect off boundary");
endmodule : btwdc_props

bind btwdc_ctrl btwdc_props #(.LONG_LOG2(LONG_LOG2), .SHORT_LOG2(SHORT_LOG2))
  u_props (.core_clk, .rst_n, .priXact, .secXact, .priDiscard, .secDiscard,
  .wrAddr, .wrActive, .wrDisconnect, .primary_system_error_n);

/* File: tb/btwdc_init_model.sv */
`timescale 1ns/1ps
module btwdc_init_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic go,
  input wire logic [7:0] lat,
  // Bridge side
  input wire logic discard,
  output btwdc_pkg::btwdc_xact_t xact
);
  logic [7:0] age_q;
  // Repeats after lat cycles when lat is set, then retires much later
  always_ff @(posedge core_clk) begin
    age_q <= go ? 8'h00 : age_q + 8'h01;
    xact.repeated <= xact.queued && lat != 8'h00 && age_q == lat;
    xact.retire <= xact.queued && lat != 8'h00 && age_q == 8'hfa;
    if (!rst_n || discard || xact.retire) begin
      xact.queued <= 1'b0;
    end else if (go) begin
      xact.queued <= 1'b1;
    end
  end
endmodule : btwdc_init_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int NL = 64;
  localparam int NS = 8;
  logic core_clk = 1'b0, rst_n = 1'b0, wrActive = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lat = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, wrAddr = 32'h0, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pGo = 1'b0, sGo = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  btwdc_pkg::btwdc_xact_t priXact, secXact;
  logic priDiscard, secDiscard, wrDisconnect, primary_system_error_n, irq, i0;
  logic [7:0] ra[5] = '{8'h3c, 8'h40, 8'h50, 8'h54, 8'h58};
  int num_errors = 0, num_checks = 0, seed = 39, errCnt = 0, e0;

  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (rst_n && !primary_system_error_n) errCnt++;

  btwdc_ctrl #(.LONG_LOG2(6), .SHORT_LOG2(3)) dut (.core_clk, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .priXact, .secXact, .priDiscard, .secDiscard, .wrAddr, .wrActive,
    .wrDisconnect, .primary_system_error_n, .irq);
  btwdc_init_model p_init (.core_clk, .rst_n, .go(pGo), .lat,
    .discard(priDiscard), .xact(priXact));
  btwdc_init_model s_init (.core_clk, .rst_n, .go(sGo), .lat,
    .discard(secDiscard), .xact(secXact));

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] exp_disc(input logic [31:0] a,
    input logic cl, input logic act);
    return 32'(act && (cl ? a[5:2] == 4'hf : a[11:2] == 10'h3ff));
  endfunction : exp_disc

  // One register write (wr high) or read; d is the data or expected data
  task automatic axi(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk("resp", 32'(er), 32'(wr ? s_axi_bresp : s_axi_rresp));
        if (!wr) chk("rdata", d, s_axi_rdata);
      end
    end
    if (!done) begin
      num_errors++;
      report_and_stop();
    end
  endtask : axi

  // Queues one delayed transaction; l is the repeat delay, zero for none
  task automatic run_tmo(input logic sec, input int n, input logic [7:0] l);
    int c;
    logic seen;
    seen = 1'b0;
    e0 = errCnt;
    @(posedge core_clk);
    lat <= l;
    pGo <= !sec;
    sGo <= sec;
    @(posedge core_clk);
    pGo <= 1'b0;
    sGo <= 1'b0;
    for (c = 2; c < 400 && !seen; c++) begin
      @(posedge core_clk);
      seen = sec ? secDiscard : priDiscard;
    end
    repeat (4) @(posedge core_clk);
    chk("discard", 32'(l == 8'h00), 32'(seen));
    chk("errPulse", 32'(l == 8'h00), 32'(errCnt - e0));
    if (seen) chk("tmoLen", 32'h1, 32'(c >= n && c <= n + 8));
    if (l == 8'h00 && !seen) report_and_stop();
  endtask : run_tmo

  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      axi(1'b0, ra[i], 32'h0, 2'b00);
    end
    repeat (2) begin
      d = $random(seed);
      axi(1'b1, 8'h3c, d, 2'b00);
      axi(1'b0, 8'h3c, d & 32'h0b000000, 2'b00);
      axi(1'b1, 8'h40, d, 2'b00);
      axi(1'b0, 8'h40, d & 32'h2, 2'b00);
    end
    axi(1'b1, 8'h80, d, 2'b10);
    axi(1'b0, 8'h80, 32'h0, 2'b10);
    axi(1'b1, 8'h3c, 32'h0, 2'b00);
    run_tmo(1'b1, NL, 8'h00);
    axi(1'b0, 8'h3c, 32'h0c000000, 2'b00);
    axi(1'b1, 8'h54, 32'h0, 2'b00);
    repeat (2) @(posedge core_clk);
    i0 = irq;
    axi(1'b1, 8'h54, 32'h3, 2'b00);
    repeat (2) @(posedge core_clk);
    chk("irqMask", 32'h1, 32'(i0 ^ irq));
    axi(1'b1, 8'h54, i0 ? 32'h0 : 32'h3, 2'b00);
    axi(1'b0, 8'h50, 32'h2, 2'b00);
    axi(1'b0, 8'h50, 32'h0, 2'b00);
    repeat (2) @(posedge core_clk);
    chk("irqClear", 32'h0, 32'(irq));
    axi(1'b1, 8'h3c, 32'h0f000000, 2'b00);
    axi(1'b0, 8'h3c, 32'h0b000000, 2'b00);
    axi(1'b1, 8'h3c, 32'h03000000, 2'b00);
    run_tmo(1'b0, NS, 8'h00);
    axi(1'b0, 8'h3c, 32'h0f000000, 2'b00);
    run_tmo(1'b0, NS, 8'h03);
    run_tmo(1'b1, NS, 8'h02);
    for (int m = 0; m < 2; m++) begin
      axi(1'b1, 8'h40, 32'(m * 2), 2'b00);
      for (int k = 0; k < 8; k++) begin
        d = $random(seed);
        if (k < 2) d[11:2] = 10'h3ff;
        else if (k < 5) d[5:2] = 4'hf;
        @(posedge core_clk);
        wrAddr <= d;
        wrActive <= k != 7;
        @(posedge core_clk);
        #1 chk("cut", exp_disc(d, m[0], k != 7), 32'(wrDisconnect));
      end
    end
    report_and_stop();
  end
endmodule : tb_top
